/* dcs_pkg.sv */
package dcs_pkg;
	// control word bit positions
	localparam int CW_RESET = 7;
	localparam int CW_JOG = 8;
	localparam int CW_VALID = 10;
	localparam int CW_RELAY1 = 11;
	localparam int CW_RELAY2 = 12;
	localparam int CW_SETUP_LO = 13;
	localparam int CW_SETUP_HI = 14;
	localparam int CW_REVERSE = 15;
	// status word bit positions
	localparam int SW_CTRL_READY = 0;
	localparam int SW_DRIVE_READY = 1;
	localparam int SW_STANDBY = 2;
	localparam int SW_TRIP = 3;
	localparam int SW_TRIP_LOCK = 6;
	localparam int SW_WARNING = 7;
	localparam int SW_AT_REF = 8;
	localparam int SW_SERIAL_OK = 9;
	localparam int SW_IN_RANGE = 10;
	localparam int SW_RUNNING = 11;
	localparam int SW_VOLTAGE = 13;
	localparam int SW_CUR_LIMIT = 14;
	localparam int SW_THERMAL = 15;
	// register byte addresses
	localparam logic [7:0] A_CTRL_IN = 8'h00;
	localparam logic [7:0] A_REF_IN = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_FREQ = 8'h0c;
	localparam logic [7:0] A_CONFIG = 8'h10;
	localparam logic [7:0] A_APPLIED = 8'h14;
	localparam logic [7:0] A_COND = 8'h18;
	localparam logic [7:0] A_OUTFREQ = 8'h1c;
	localparam logic [7:0] A_REFLIM = 8'h20;
	localparam logic [7:0] A_FLIM = 8'h24;
	localparam logic [7:0] A_TIMEOUT = 8'h28;
	localparam logic [7:0] A_TRIPDLY = 8'h2c;
	localparam logic [7:0] A_JOG = 8'h30;
	// config register fields
	localparam int CF_RLY1_SRC = 0;
	localparam int CF_RLY2_SRC = 1;
	localparam int CF_MULTI = 2;
	localparam int CF_REV_LO = 3;
	localparam int CF_REV_HI = 4;
	// reversing source choices
	localparam logic [1:0] REV_DIGITAL = 2'h0;
	localparam logic [1:0] REV_BUS = 2'h1;
	localparam logic [1:0] REV_AND = 2'h2;
	localparam logic [1:0] REV_OR = 2'h3;
	localparam logic [4:0] CONFIG_RST = 5'h00;
	localparam logic [15:0] SCALE_FULL = 16'h4000;
	localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
	localparam logic [31:0] TRIPDLY_RST = 32'h0000_0000;

	typedef struct packed {
		logic ctrl_ready;
		logic coast_in_n;
		logic serial_coast;
		logic can_start;
		logic tripped;
		logic trip_lock;
		logic warning;
		logic panel_stop;
		logic hand_mode;
		logic start_held;
		logic dc_fault;
		logic temp_fault;
		logic rev_input;
		logic over_current;
	} dcs_cond_t;

	typedef enum logic [1:0] {
		DCS_ST_OK,
		DCS_ST_LIMIT,
		DCS_ST_TRIP
	} dcs_trip_state_t;
endpackage

/* dcs_drive_words.sv */
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// R1: two 16-bit words each way, fixed order
// R2: trip cleared only on bit 07 rise
// R3: bit 08 selects jog frequency
// R4: bit 10 low ignores whole control word
// R5: bits 11/12 drive relays if selected
// R6: bus timeout drops bus-driven relays
// R7: bits 14:13 choose setup if multi-setup
// R8: bit 15 reverses per reversing source
// R9: status 00 ready, zero when tripped
// R10: status 01 ready with coast request
// R11: status 02 able to start
// R12: status 03 tripped, needs reset
// R13: status 06 trip lock; others unused
// R14: status 07 any warning
// R15: status 08 speed equals reference
// R16: status 09 serial control permitted
// R17: status 10 frequency strictly within limits
// R18: status 11 start held or running
// R19: status 14 current limit, then trip
// R20: status 13 dc voltage, 15 thermal
// R21: reference signed, 16384 is full span
// R22: negative reference requests reversal
// R23: frequency word scaled to limits span
// R24: reply words rebuilt every cycle
module dcs_drive_words (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic coast_pin_n,
	input wire logic rev_pin,
	output logic relay1,
	output logic relay2,
	output logic [1:0] active_setup,
	output logic reverse_cmd,
	output logic jog_select,
	output logic trip_reset,
	output logic trip
);
	logic [15:0] ctrl_reg;
	logic [15:0] ref_reg;
	logic [15:0] applied_reg;
	logic [15:0] status_reg;
	logic [15:0] freq_reg;
	logic [4:0] config_reg;
	logic [13:0] cond_reg;
	logic [15:0] outfreq_reg;
	logic [15:0] speed_reg;
	logic [31:0] reflim_reg;
	logic [31:0] flim_reg;
	logic [31:0] timeout_reg;
	logic [31:0] tripdly_reg;
	logic [15:0] jog_reg;
	logic [31:0] idle_cnt_reg;
	logic [31:0] oc_cnt_reg;
	logic bus_dead_reg;
	logic new_word_reg;
	logic prev_reset_reg;
	logic coast_s1_reg, coast_s2_reg, rev_s1_reg, rev_s2_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	dcs_pkg::dcs_trip_state_t trip_state_reg;
	dcs_pkg::dcs_cond_t cond;
	logic take;
	logic valid_word;
	logic rev_bus, rev_ok;
	logic [15:0] status_next;
	logic [15:0] freq_next;

	// percent of span: value relative to low end, 16384 at high end
	function automatic logic [15:0] dcs_scale(input logic [15:0] val, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [15:0] span;
		logic [31:0] q;
		span = hi - lo;
		q = 32'h0;
		if (span != 16'h0)
			q = ({16'h0, val - lo} * 32'(dcs_pkg::SCALE_FULL)) / {16'h0, span};
		return q[15:0];
	endfunction

	assign cond = dcs_pkg::dcs_cond_t'(cond_reg);
	assign take = hsel && hready && htrans[1];
	assign valid_word = ctrl_reg[dcs_pkg::CW_VALID]; // [R4]

	// pins cross into hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coast_s1_reg <= 1'b1;
			coast_s2_reg <= 1'b1;
			rev_s1_reg <= 1'b0;
			rev_s2_reg <= 1'b0;
		end else begin
			coast_s1_reg <= coast_pin_n;
			coast_s2_reg <= coast_s1_reg;
			rev_s1_reg <= rev_pin;
			rev_s2_reg <= rev_s1_reg;
		end
	end

	// ahb write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= take && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= 16'h0000;
			ref_reg <= 16'h0000;
			config_reg <= dcs_pkg::CONFIG_RST;
			cond_reg <= 14'h0000;
			outfreq_reg <= 16'h0000;
			speed_reg <= 16'h0000;
			reflim_reg <= 32'h0000_0000;
			flim_reg <= 32'h0000_0000;
			timeout_reg <= dcs_pkg::TIMEOUT_RST;
			tripdly_reg <= dcs_pkg::TRIPDLY_RST;
			jog_reg <= 16'h0000;
			new_word_reg <= 1'b0;
		end else begin
			new_word_reg <= 1'b0;
			if (wr_pend_reg) begin
				case (wr_addr_reg)
					dcs_pkg::A_CTRL_IN: begin
						ctrl_reg <= hwdata[15:0]; // [R1]
						new_word_reg <= 1'b1;
					end
					dcs_pkg::A_REF_IN: ref_reg <= hwdata[15:0]; // [R1]
					dcs_pkg::A_CONFIG: config_reg <= hwdata[4:0];
					dcs_pkg::A_COND: cond_reg <= hwdata[13:0];
					dcs_pkg::A_OUTFREQ: begin
						outfreq_reg <= hwdata[15:0];
						speed_reg <= hwdata[31:16];
					end
					dcs_pkg::A_REFLIM: reflim_reg <= hwdata;
					dcs_pkg::A_FLIM: flim_reg <= hwdata;
					dcs_pkg::A_TIMEOUT: timeout_reg <= hwdata;
					dcs_pkg::A_TRIPDLY: tripdly_reg <= hwdata;
					dcs_pkg::A_JOG: jog_reg <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// applied word: only taken when marked valid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			applied_reg <= 16'h0000;
			prev_reset_reg <= 1'b0;
			trip_reset <= 1'b0;
		end else begin
			trip_reset <= 1'b0;
			if (new_word_reg && valid_word) begin // [R4]
				applied_reg <= ctrl_reg;
				prev_reset_reg <= ctrl_reg[dcs_pkg::CW_RESET];
				trip_reset <= ctrl_reg[dcs_pkg::CW_RESET] && !prev_reset_reg; // [R2]
			end
		end
	end

	// bus silence watchdog; zero interval disables it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt_reg <= 32'h0;
			bus_dead_reg <= 1'b0;
		end else if (take) begin
			idle_cnt_reg <= 32'h0;
			bus_dead_reg <= 1'b0;
		end else if (timeout_reg != 32'h0 && idle_cnt_reg >= timeout_reg) begin
			bus_dead_reg <= 1'b1; // [R6]
		end else begin
			idle_cnt_reg <= idle_cnt_reg + 32'h1;
		end
	end

	// overcurrent trip timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trip_state_reg <= dcs_pkg::DCS_ST_OK;
			oc_cnt_reg <= 32'h0;
		end else begin
			case (trip_state_reg)
				dcs_pkg::DCS_ST_OK: begin
					oc_cnt_reg <= 32'h0;
					if (cond.over_current)
						trip_state_reg <= dcs_pkg::DCS_ST_LIMIT;
				end
				dcs_pkg::DCS_ST_LIMIT: begin
					if (!cond.over_current)
						trip_state_reg <= dcs_pkg::DCS_ST_OK;
					else if (oc_cnt_reg >= tripdly_reg)
						trip_state_reg <= dcs_pkg::DCS_ST_TRIP; // [R19]
					else
						oc_cnt_reg <= oc_cnt_reg + 32'h1;
				end
				dcs_pkg::DCS_ST_TRIP: begin
					if (trip_reset) // [R2]
						trip_state_reg <= dcs_pkg::DCS_ST_OK;
				end
				default: trip_state_reg <= dcs_pkg::DCS_ST_OK;
			endcase
		end
	end

	always_comb begin
		rev_bus = applied_reg[dcs_pkg::CW_REVERSE] || ref_reg[15]; // [R22]
		case (config_reg[dcs_pkg::CF_REV_HI:dcs_pkg::CF_REV_LO])
			dcs_pkg::REV_BUS: rev_ok = rev_bus; // [R8]
			dcs_pkg::REV_AND: rev_ok = rev_bus && rev_s2_reg;
			dcs_pkg::REV_OR: rev_ok = rev_bus || rev_s2_reg;
			default: rev_ok = rev_s2_reg;
		endcase
	end

	// status and frequency words are recomputed every cycle
	always_comb begin
		logic tripped;
		logic ready;
		tripped = cond.tripped || trip_state_reg == dcs_pkg::DCS_ST_TRIP;
		ready = cond.ctrl_ready && !tripped;
		status_next = 16'h0000; // [R13]
		status_next[dcs_pkg::SW_CTRL_READY] = ready; // [R9]
		status_next[dcs_pkg::SW_DRIVE_READY] = ready && (!coast_s2_reg || cond.serial_coast); // [R10]
		status_next[dcs_pkg::SW_STANDBY] = ready && cond.can_start; // [R11]
		status_next[dcs_pkg::SW_TRIP] = tripped; // [R12]
		status_next[dcs_pkg::SW_TRIP_LOCK] = cond.trip_lock; // [R13]
		status_next[dcs_pkg::SW_WARNING] = cond.warning || cond.dc_fault || cond.temp_fault; // [R14]
		status_next[dcs_pkg::SW_AT_REF] = speed_reg == ref_reg; // [R15]
		status_next[dcs_pkg::SW_SERIAL_OK] = !cond.panel_stop && !cond.hand_mode; // [R16]
		status_next[dcs_pkg::SW_IN_RANGE] = outfreq_reg > flim_reg[15:0] && outfreq_reg < flim_reg[31:16]; // [R17]
		status_next[dcs_pkg::SW_RUNNING] = cond.start_held || outfreq_reg != 16'h0; // [R18]
		status_next[dcs_pkg::SW_VOLTAGE] = cond.dc_fault; // [R20]
		status_next[dcs_pkg::SW_CUR_LIMIT] = cond.over_current; // [R19]
		status_next[dcs_pkg::SW_THERMAL] = cond.temp_fault; // [R20]
		freq_next = dcs_scale(outfreq_reg, flim_reg[15:0], flim_reg[31:16]); // [R23]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= 16'h0000;
			freq_reg <= 16'h0000;
		end else begin
			status_reg <= status_next; // [R24]
			freq_reg <= freq_next; // [R24]
		end
	end

	// drive-side outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			relay1 <= 1'b0;
			relay2 <= 1'b0;
			active_setup <= 2'h0;
			reverse_cmd <= 1'b0;
			jog_select <= 1'b0;
			trip <= 1'b0;
		end else begin
			// relays follow the word only while the bus is alive
			relay1 <= config_reg[dcs_pkg::CF_RLY1_SRC] && applied_reg[dcs_pkg::CW_RELAY1] && !bus_dead_reg; // [R5] [R6]
			relay2 <= config_reg[dcs_pkg::CF_RLY2_SRC] && applied_reg[dcs_pkg::CW_RELAY2] && !bus_dead_reg; // [R5] [R6]
			if (config_reg[dcs_pkg::CF_MULTI])
				active_setup <= applied_reg[dcs_pkg::CW_SETUP_HI:dcs_pkg::CW_SETUP_LO]; // [R7]
			reverse_cmd <= rev_ok; // [R8] [R22]
			jog_select <= applied_reg[dcs_pkg::CW_JOG]; // [R3]
			trip <= trip_state_reg == dcs_pkg::DCS_ST_TRIP;
		end
	end

	// read data; ref word reads back exactly as written, sign included
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (hready) begin
			hrdata <= 32'h0;
			if (take && !hwrite) begin
				case (haddr[7:0])
					dcs_pkg::A_CTRL_IN: hrdata <= {16'h0, ctrl_reg};
					dcs_pkg::A_REF_IN: hrdata <= {16'h0, ref_reg}; // [R21]
					dcs_pkg::A_STATUS: hrdata <= {16'h0, status_reg};
					dcs_pkg::A_FREQ: hrdata <= {16'h0, freq_reg};
					dcs_pkg::A_CONFIG: hrdata <= {27'h0, config_reg};
					dcs_pkg::A_APPLIED: hrdata <= {16'h0, applied_reg};
					dcs_pkg::A_COND: hrdata <= {18'h0, cond_reg};
					dcs_pkg::A_OUTFREQ: hrdata <= {speed_reg, outfreq_reg};
					dcs_pkg::A_REFLIM: hrdata <= reflim_reg;
					dcs_pkg::A_FLIM: hrdata <= flim_reg;
					dcs_pkg::A_TIMEOUT: hrdata <= timeout_reg;
					dcs_pkg::A_TRIPDLY: hrdata <= tripdly_reg;
					dcs_pkg::A_JOG: hrdata <= {16'h0, jog_reg}; // [R3]
					default: hrdata <= 32'h0;
				endcase
			end
		end
	end
endmodule // dcs_drive_words

/* dcs_drive_words_props.sv */
`timescale 1ns/10ps
module dcs_drive_words_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic coast_pin_n,
	input wire logic rev_pin,
	input wire logic relay1,
	input wire logic relay2,
	input wire logic [1:0] active_setup,
	input wire logic reverse_cmd,
	input wire logic jog_select,
	input wire logic trip_reset,
	input wire logic trip
);
	logic ph_v, ph_w, oc;
	logic [7:0] ph_a, cnt;
	logic [15:0] cw;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) ph_v <= 1'b0;
		else if (hready) ph_v <= hsel && htrans[1];
	end
	always_ff @(posedge hclk) begin
		if (hready && hsel && htrans[1]) begin
			ph_w <= hwrite;
			ph_a <= haddr[7:0];
		end
	end
	// edges since the last valid control word; invalid words must not count as a cause
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'hff;
			cw <= 16'h0000;
			oc <= 1'b0;
		end else if (ph_v && ph_w && ph_a == dcs_pkg::A_CTRL_IN && hwdata[dcs_pkg::CW_VALID]) begin
			cnt <= 8'h00;
			cw <= hwdata[15:0];
		end else begin
			if (cnt != 8'hff) cnt <= cnt + 8'h01;
			if (ph_v && ph_w && ph_a == dcs_pkg::A_COND) oc <= hwdata[0];
		end
	end
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	pulse_one_a: assert property (trip_reset |=> !trip_reset)
		else $error("trip reset pulse too long");
	pulse_cause_a: assert property (trip_reset |-> cnt <= 8'd6 && cw[dcs_pkg::CW_RESET])
		else $error("trip reset without a fresh reset bit");
	relay1_cause_a: assert property ($rose(relay1) |-> cnt <= 8'd6 && cw[dcs_pkg::CW_RELAY1])
		else $error("relay 1 raised without its bit");
	relay2_cause_a: assert property ($rose(relay2) |-> cnt <= 8'd6 && cw[dcs_pkg::CW_RELAY2])
		else $error("relay 2 raised without its bit");
	jog_follow_a: assert property ($changed(jog_select) |-> cnt <= 8'd6 && jog_select == cw[dcs_pkg::CW_JOG])
		else $error("jog select moved without a valid word");
	status_narrow_a: assert property (ph_v && !ph_w && ph_a == dcs_pkg::A_STATUS |-> hrdata[31:16] == 16'h0000)
		else $error("status word wider than 16 bits");
	trip_cause_a: assert property ($rose(trip) |-> oc)
		else $error("trip without overcurrent");
endmodule // dcs_drive_words_chk
bind dcs_drive_words dcs_drive_words_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .coast_pin_n(coast_pin_n), .rev_pin(rev_pin), .relay1(relay1),
	.relay2(relay2), .active_setup(active_setup), .reverse_cmd(reverse_cmd), .jog_select(jog_select),
	.trip_reset(trip_reset), .trip(trip));

/* dcs_host_model.sv */
`timescale 1ns/10ps
module dcs_host_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	// released lines show the inverse so a stale value can never pass for a fresh one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= w ? d : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		hwdata <= ~hwdata;
	endtask
	task automatic put_words(input logic [15:0] cw, input logic [15:0] rf);
		logic [31:0] r;
		xfer(1'b1, dcs_pkg::A_CTRL_IN, {16'h0000, cw}, r);
		xfer(1'b1, dcs_pkg::A_REF_IN, {16'h0000, rf}, r);
	endtask
endmodule // dcs_host_model

/* tb_drive_control_status_words.sv */
`timescale 1ns/10ps
module tb_drive_control_status_words;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic coast_pin_n = 1'b1;
	logic rev_pin = 1'b0;
	logic hsel, hwrite, hready, hresp, relay1, relay2, reverse_cmd, jog_select, trip_reset, trip, rx;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, active_setup;
	logic [2:0] hsize;
	logic [15:0] cond_t [12] = '{16'h2000, 16'h2200, 16'h2800, 16'h2400, 16'h0100, 16'h0080,
		16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0000};
	logic [15:0] exp_t [12] = '{16'h0201, 16'h0008, 16'h0003, 16'h0004, 16'h0040, 16'h0080,
		16'h0000, 16'h0000, 16'h0800, 16'h2080, 16'h8080, 16'h0000};
	logic [15:0] msk_t [12] = '{16'h020b, 16'h0009, 16'h0003, 16'h0004, 16'h0040, 16'h0080,
		16'h0200, 16'h0200, 16'h0800, 16'h2080, 16'h8080, 16'he8cf};
	int errors = 0;
	int n_tests = 0;
	int pulses = 0;
	always #4 hclk = ~hclk;
	dcs_drive_words dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .coast_pin_n(coast_pin_n), .rev_pin(rev_pin), .relay1(relay1),
		.relay2(relay2), .active_setup(active_setup), .reverse_cmd(reverse_cmd), .jog_select(jog_select),
		.trip_reset(trip_reset), .trip(trip));
	dcs_host_model host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	always @(posedge hclk) if (trip_reset === 1'b1) pulses++;
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd);
	endtask
	// margin over the three-edge apply path and the two-flop pin sync
	task automatic settle;
		repeat (6) @(posedge hclk);
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		host.xfer(1'b0, a, 32'h00000000, rd);
		n_tests++;
		if ((rd & m) !== (e & m)) begin
			errors++;
			$display("MISMATCH t=%0t reg %h got %h exp %h", $time, a, rd, e);
		end
	endtask
	task automatic chk_pin(input logic [1:0] got, input logic [1:0] e);
		n_tests++;
		if (got !== e) begin
			errors++;
			$display("MISMATCH t=%0t pins got %b exp %b", $time, got, e);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		chk_pin({relay2, relay1}, 2'h0);
		chk_pin(active_setup, 2'h0);
		chk_pin({jog_select, reverse_cmd}, 2'h0);
		chk_pin({trip_reset, trip}, 2'h0);
		chk_reg(dcs_pkg::A_CONFIG, {27'h0, dcs_pkg::CONFIG_RST}, '1);
		chk_reg(dcs_pkg::A_TIMEOUT, dcs_pkg::TIMEOUT_RST, '1);
		chk_reg(dcs_pkg::A_TRIPDLY, dcs_pkg::TRIPDLY_RST, '1);
		wr(8'h3c, 32'h00001234);
		chk_reg(8'h3c, 32'h00000000, '1);
		host.put_words(16'h1c00, 16'h0000);
		settle;
		chk_pin({relay2, relay1}, 2'h0);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000400);
		wr(dcs_pkg::A_CONFIG, 32'h00000003);
		wr(dcs_pkg::A_CTRL_IN, 32'h00001800);
		settle;
		chk_pin({relay2, relay1}, 2'h0);
		host.put_words(16'h1c00, 16'h0000);
		settle;
		chk_pin({relay2, relay1}, 2'h3);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000100);
		settle;
		chk_pin({relay2, relay1}, 2'h3);
		chk_pin({jog_select, relay1}, 2'h1);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000500);
		settle;
		chk_pin({jog_select, relay1}, 2'h2);
		wr(dcs_pkg::A_CONFIG, 32'h00000004);
		for (int s = 0; s < 4; s++) begin
			wr(dcs_pkg::A_CTRL_IN, 32'h00000400 | (s << 13));
			settle;
			chk_pin(active_setup, s[1:0]);
		end
		for (int k = 0; k < 16; k++) begin
			wr(dcs_pkg::A_CONFIG, (k >> 2) << 3);
			rev_pin <= k[1];
			host.put_words(16'h0400 | {k[0], 15'h0000}, 16'h2000);
			settle;
			rx = (k[3:2] == dcs_pkg::REV_BUS) ? k[0] : (k[3:2] == dcs_pkg::REV_AND) ? (k[0] & k[1]) :
				(k[3:2] == dcs_pkg::REV_OR) ? (k[0] | k[1]) : k[1];
			chk_pin({1'b0, reverse_cmd}, {1'b0, rx});
		end
		rev_pin <= 1'b0;
		wr(dcs_pkg::A_CONFIG, 32'h00000008);
		host.put_words(16'h0400, 16'he000);
		settle;
		chk_pin({1'b0, reverse_cmd}, 2'h1);
		for (int i = 0; i < 12; i++) begin
			wr(dcs_pkg::A_COND, {16'h0000, cond_t[i]});
			settle;
			chk_reg(dcs_pkg::A_STATUS, {16'h0, exp_t[i]}, {16'h0, msk_t[i] | 16'h1030});
		end
		// coast pin low while ready must show drive ready
		coast_pin_n <= 1'b0;
		wr(dcs_pkg::A_COND, 32'h00002000);
		settle;
		chk_reg(dcs_pkg::A_STATUS, 32'h00000003, 32'h00000003);
		coast_pin_n <= 1'b1;
		wr(dcs_pkg::A_FLIM, {16'd500, 16'd100});
		wr(dcs_pkg::A_OUTFREQ, 32'd300);
		settle;
		chk_reg(dcs_pkg::A_FREQ, {17'h0, dcs_pkg::SCALE_FULL[15:1]}, '1);
		chk_reg(dcs_pkg::A_STATUS, 32'h00000c00, 32'h00000c00);
		wr(dcs_pkg::A_OUTFREQ, 32'd500);
		settle;
		chk_reg(dcs_pkg::A_FREQ, {16'h0000, dcs_pkg::SCALE_FULL}, '1);
		chk_reg(dcs_pkg::A_STATUS, 32'h00000800, 32'h00000c00);
		// speed equal to the last reference, output frequency zero
		wr(dcs_pkg::A_OUTFREQ, 32'he000_0000);
		settle;
		chk_reg(dcs_pkg::A_STATUS, 32'h00000100, 32'h00000900);
		wr(dcs_pkg::A_TRIPDLY, 32'd5);
		wr(dcs_pkg::A_COND, 32'h00002001);
		repeat (12) @(posedge hclk);
		chk_reg(dcs_pkg::A_STATUS, 32'h00004000, 32'h00004000);
		chk_pin({1'b0, trip}, 2'h1);
		wr(dcs_pkg::A_COND, 32'h00002000);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000400);
		pulses = 0;
		wr(dcs_pkg::A_CTRL_IN, 32'h00000480);
		settle;
		chk_pin({1'b0, trip}, 2'h0);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000480);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000080);
		wr(dcs_pkg::A_CTRL_IN, 32'h00000480);
		settle;
		chk_pin(pulses[1:0], 2'h1);
		wr(dcs_pkg::A_TIMEOUT, 32'd20);
		wr(dcs_pkg::A_CONFIG, 32'h00000003);
		host.put_words(16'h1c00, 16'h0000);
		settle;
		chk_pin({relay2, relay1}, 2'h3);
		repeat (30) @(posedge hclk);
		chk_pin({relay2, relay1}, 2'h0);
		tally_and_finish;
	end
endmodule // tb_drive_control_status_words
